// ==== rtl/cke_power_defines.svh ====
// constants for the clock-enable power state and init block
// assumes inclusion by bare name from the package and the design
`ifndef CKE_POWER_DEFINES_SVH
`define CKE_POWER_DEFINES_SVH

`define CLK_PERIOD_NS     100
`define INIT_WAIT_US      500
`define INIT_WAIT_CYC     ((`INIT_WAIT_US * 1000) / `CLK_PERIOD_NS)
`define TXPR_NCK          5
`define TXS_NCK_DEF       8
`define TXP_NCK_DEF       3
`define TRFC_NCK_DEF      16
`define TMRD_NCK_DEF      4
`define TZQINIT_NCK_DEF   512
`define TDLLK_NCK_DEF     512
`define BURST_NCK_DEF     4
`define CNT_W             16
`define CNT_ZERO          16'h0000
`define BANKS             8

`endif

// ==== rtl/cke_power_pkg.sv ====
// types shared by the clock-enable power state and init block
// assumes the defines header sits beside it
`include "cke_power_defines.svh"
package cke_power_pkg;

  typedef enum logic [2:0] {
    cmd_nop, cmd_act, cmd_rw, cmd_pre, cmd_ref, cmd_mrs, cmd_zqcl, cmd_other
  } cmd_e;

  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic       a10;
    logic [2:0] bank;
  } cmd_s;

  typedef enum logic [3:0] {
    st_reset, st_wait_cke, st_wait_txpr, st_mr2, st_mr3, st_mr1, st_mr0, st_zq,
    st_zq_wait, st_idle, st_active, st_pd_pre, st_pd_act, st_self_ref
  } state_e;

  typedef struct packed {
    logic ready;
    logic odt_hiz;
    logic self_refresh;
    logic power_down;
    logic active_pd;
    logic all_idle;
    logic proto_error;
  } status_s;

endpackage

// ==== rtl/cke_power_state.sv ====
// clock-enable driven power state tracker and power-up init sequencer
// assumes cke, reset pin, odt and command pins come from the controller
//
// Operation
// - cke judged on previous and current sample
// - power-down entry/exit only with nop/deselect
// - self refresh exit only with nop/deselect
// - banks closed gives precharge, else active power-down
// - self refresh from idle with refresh, cke falling
// - idle needs closed banks, no burst, timers done
// - no internal refresh in power-down
// - odt off in self refresh, ignored by transitions
// - 500 us internal init after reset release
// - odt high impedance until cke first high
// - zqcl then wait tdllk and tzqinit
// - deselect equals nop everywhere
`timescale 1ns/1ps
`include "cke_power_defines.svh"

module cke_power_state #(
  parameter int INIT_WAIT_CYC = `INIT_WAIT_CYC,
  parameter int TXS_NCK       = `TXS_NCK_DEF,
  parameter int TXP_NCK       = `TXP_NCK_DEF,
  parameter int TRFC_NCK      = `TRFC_NCK_DEF,
  parameter int TMRD_NCK      = `TMRD_NCK_DEF,
  parameter int TZQINIT_NCK   = `TZQINIT_NCK_DEF,
  parameter int TDLLK_NCK     = `TDLLK_NCK_DEF,
  parameter int BURST_NCK     = `BURST_NCK_DEF
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire logic                   mem_reset_n,
  input  wire logic                   cke,
  input  wire logic                   odt,
  input  wire cke_power_pkg::cmd_s    cmd,
  input  wire logic                   a0,
  input  wire logic                   a8,
  output logic                        odt_enable,
  output cke_power_pkg::status_s      status,
  output cke_power_pkg::state_e       state
);
  import cke_power_pkg::*;

  // ************************************************************
  // reset release and input synchronisers
  // ************************************************************
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // pins come from outside this clock; two stages before any use
  logic [1:0] mrst_sync_r, cke_sync_r, odt_sync_r;
  cmd_s       cmd_s1_r, cmd_s2_r;
  logic [1:0] a_s1_r, a_s2_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mrst_sync_r <= 2'b00;
      cke_sync_r  <= 2'b00;
      odt_sync_r  <= 2'b00;
      cmd_s1_r    <= '1;
      cmd_s2_r    <= '1;
      a_s1_r      <= 2'b00;
      a_s2_r      <= 2'b00;
    end else begin
      mrst_sync_r <= {mrst_sync_r[0], mem_reset_n};
      cke_sync_r  <= {cke_sync_r[0], cke};
      odt_sync_r  <= {odt_sync_r[0], odt};
      cmd_s1_r    <= cmd;
      cmd_s2_r    <= cmd_s1_r;
      a_s1_r      <= {a8, a0};
      a_s2_r      <= a_s1_r;
    end
  end
  wire mrst_n = mrst_sync_r[1];
  wire cke_n  = cke_sync_r[1];

  // ************************************************************
  // command decode and cke history
  // ************************************************************
  logic cke_prev_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cke_prev_r <= 1'b0;
    else        cke_prev_r <= cke_n;
  end

  cmd_e op;
  always_comb begin
    if (cmd_s2_r.cs_n) op = cmd_nop;
    else begin
      case ({cmd_s2_r.ras_n, cmd_s2_r.cas_n, cmd_s2_r.we_n})
        3'b111:  op = cmd_nop;
        3'b011:  op = cmd_act;
        3'b101,
        3'b100:  op = cmd_rw;
        3'b010:  op = cmd_pre;
        3'b001:  op = cmd_ref;
        3'b000:  op = cmd_mrs;
        3'b110:  op = cmd_zqcl;
        default: op = cmd_other;
      endcase
    end
  end
  wire is_nop  = (op == cmd_nop);
  wire is_zqcl = (op == cmd_zqcl) && cmd_s2_r.a10;
  wire cke_fall = cke_prev_r && !cke_n;
  wire cke_rise = !cke_prev_r && cke_n;

  // ************************************************************
  // bank, burst and timing tracking
  // ************************************************************
  logic [`BANKS-1:0] bank_open_r;
  logic [`CNT_W-1:0] busy_r, burst_r, dllk_r;
  wire  all_closed = (bank_open_r == '0);
  wire  banks_idle = all_closed && (burst_r == `CNT_ZERO)
                   && (busy_r == `CNT_ZERO) && cke_n;
  state_e state_r;
  wire  normal = (state_r == st_idle) || (state_r == st_active);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) bank_open_r <= '0;
    else if (!mrst_n) bank_open_r <= '0;
    else if (normal && cke_prev_r) begin
      if (op == cmd_act) bank_open_r[cmd_s2_r.bank] <= 1'b1;
      else if (op == cmd_pre && cmd_s2_r.a10) bank_open_r <= '0;
      else if (op == cmd_pre) bank_open_r[cmd_s2_r.bank] <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) burst_r <= `CNT_ZERO;
    else if (normal && cke_prev_r && op == cmd_rw) burst_r <= `CNT_W'(BURST_NCK);
    else if (burst_r != `CNT_ZERO) burst_r <= burst_r - 1'b1;
  end

  // one shared countdown for refresh, mode load and exit timings
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) busy_r <= `CNT_ZERO;
    else if (!mrst_n) busy_r <= `CNT_W'(INIT_WAIT_CYC);
    else if (state_r == st_self_ref && cke_rise) busy_r <= `CNT_W'(TXS_NCK);
    else if ((state_r == st_pd_pre || state_r == st_pd_act) && cke_rise)
      busy_r <= `CNT_W'(TXP_NCK);
    else if (state_r == st_wait_cke && cke_rise)
      busy_r <= `CNT_W'((TXS_NCK > `TXPR_NCK) ? TXS_NCK : `TXPR_NCK);
    else if (op == cmd_mrs && cke_n) busy_r <= `CNT_W'(TMRD_NCK);
    else if (op == cmd_ref && cke_n && normal) busy_r <= `CNT_W'(TRFC_NCK);
    else if (is_zqcl && state_r == st_zq) busy_r <= `CNT_W'(TZQINIT_NCK);
    else if (busy_r != `CNT_ZERO) busy_r <= busy_r - 1'b1;
  end

  // dll lock countdown armed by the dll-reset mode load
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) dllk_r <= `CNT_ZERO;
    else if (state_r == st_mr0 && op == cmd_mrs && cmd_s2_r.ba == 3'b000 && a_s2_r[1])
      dllk_r <= `CNT_W'(TDLLK_NCK);
    else if (dllk_r != `CNT_ZERO) dllk_r <= dllk_r - 1'b1;
  end

  // ************************************************************
  // power state and init sequence
  // ************************************************************
  logic proto_err_r;
  logic banks_idle_prev;
  wire  mrs_ok = (op == cmd_mrs) && (busy_r == `CNT_ZERO);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= st_reset;
    end else if (!mrst_n) begin
      state_r <= st_reset;
    end else begin
      case (state_r)
        st_reset:    state_r <= st_wait_cke;
        st_wait_cke: if (cke_rise && busy_r == `CNT_ZERO && is_nop)
                       state_r <= st_wait_txpr;
        st_wait_txpr: if (busy_r == `CNT_ZERO) state_r <= st_mr2;
        st_mr2: if (mrs_ok && cmd_s2_r.ba == 3'b010) state_r <= st_mr3;
        st_mr3: if (mrs_ok && cmd_s2_r.ba == 3'b011) state_r <= st_mr1;
        st_mr1: if (mrs_ok && cmd_s2_r.ba == 3'b001 && !a_s2_r[0])
                  state_r <= st_mr0;
        st_mr0: if (mrs_ok && cmd_s2_r.ba == 3'b000 && a_s2_r[1])
                  state_r <= st_zq;
        st_zq:  if (is_zqcl && busy_r == `CNT_ZERO) state_r <= st_zq_wait;
        st_zq_wait: if (busy_r == `CNT_ZERO && dllk_r == `CNT_ZERO)
                      state_r <= st_idle;
        st_idle, st_active: begin
          if (cke_fall && op == cmd_ref && banks_idle_prev)
            state_r <= st_self_ref;
          else if (cke_fall && is_nop)
            state_r <= all_closed ? st_pd_pre : st_pd_act;
          else
            state_r <= all_closed ? st_idle : st_active;
        end
        st_pd_pre: if (cke_rise && is_nop) state_r <= st_idle;
        st_pd_act: if (cke_rise && is_nop) state_r <= st_active;
        st_self_ref: if (cke_rise && is_nop) state_r <= st_idle;
        default: state_r <= st_reset;
      endcase
    end
  end

  // idle judged at the edge before the falling cke, cke itself high then
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) banks_idle_prev <= 1'b0;
    else        banks_idle_prev <= banks_idle && !is_zqcl;
  end

  // illegal command at a power transition; sticky until memory reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) proto_err_r <= 1'b0;
    else if (!mrst_n) proto_err_r <= 1'b0;
    else if ((normal && cke_fall && !is_nop && op != cmd_ref)
          || ((state_r == st_pd_pre || state_r == st_pd_act
               || state_r == st_self_ref) && cke_rise && !is_nop))
      proto_err_r <= 1'b1;
  end

  // ************************************************************
  // termination and outputs
  // ************************************************************
  logic cke_seen_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cke_seen_r <= 1'b0;
    else if (!mrst_n) cke_seen_r <= 1'b0;
    else if (state_r != st_reset && cke_n) cke_seen_r <= 1'b1;
  end

  // odt never steers the power state; it only gates termination
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) odt_enable <= 1'b0;
    else odt_enable <= cke_seen_r && (state_r != st_self_ref)
                       && odt_sync_r[1];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) status <= '0;
    else begin
      status.ready        <= normal;
      status.odt_hiz      <= !(cke_seen_r && state_r != st_self_ref);
      status.self_refresh <= (state_r == st_self_ref);
      // no internal refresh scheduled in either power-down
      status.power_down   <= (state_r == st_pd_pre) || (state_r == st_pd_act);
      status.active_pd    <= (state_r == st_pd_act);
      status.all_idle     <= banks_idle && normal;
      status.proto_error  <= proto_err_r;
    end
  end

  assign state = state_r;

endmodule // cke_power_state

// ==== dv/cke_power_props.sv ====
// checker for the clock-enable power state block
// assumes it is bound onto cke_power_state
`timescale 1ns/1ps
module cke_power_props #(
  parameter int INIT_WAIT_CYC = 20,
  parameter int TZQINIT_NCK   = 8,
  parameter int TDLLK_NCK     = 8
) (
  input wire logic                   clock,
  input wire logic                   reset_n,
  input wire logic                   mem_reset_n,
  input wire logic                   cke,
  input wire logic                   odt,
  input wire cke_power_pkg::cmd_s    cmd,
  input wire logic                   a0,
  input wire logic                   a8,
  input wire logic                   odt_enable,
  input wire cke_power_pkg::status_s status,
  input wire cke_power_pkg::state_e  state
);
  import cke_power_pkg::*;
  logic [15:0] hi_cnt_r;
  logic [15:0] zq_cnt_r;
  // pin-side count runs ahead of the synced one, so it can only be larger
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_r <= 16'h0000;
      zq_cnt_r <= 16'h0000;
    end else begin
      hi_cnt_r <= mem_reset_n ? hi_cnt_r + 16'h0001 : 16'h0000;
      zq_cnt_r <= (state == st_zq_wait) ? zq_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence cke_fall_s;
    $past(cke) && !cke && state == st_idle && status.all_idle;
  endsequence
  sequence cke_rise_pd_s;
    !$past(cke) && cke && state == st_pd_pre;
  endsequence
  AST_ODT_HIZ_RST: assert property (!mem_reset_n [*8] |-> status.odt_hiz)
    else $error("termination not high impedance in reset");
  AST_ODT_OFF_HIZ: assert property (status.odt_hiz |-> !odt_enable)
    else $error("termination on before cke seen high");
  AST_ODT_OFF_SR: assert property (status.self_refresh |-> !odt_enable)
    else $error("termination on in self refresh");
  AST_PD_ENTRY: assert property (cke_fall_s ##0 cmd.cs_n |-> ##[2:4] state == st_pd_pre)
    else $error("no power-down entry");
  AST_SR_ENTRY: assert property (cke_fall_s ##0 (!cmd.cs_n && !cmd.ras_n && !cmd.cas_n
    && cmd.we_n) |-> ##[2:4] state == st_self_ref) else $error("no self refresh entry");
  AST_SR_FROM_IDLE: assert property ((state == st_self_ref && $past(state) != st_self_ref)
    |-> $past(state) == st_idle) else $error("self refresh entered from a busy state");
  AST_PROTO: assert property (cke_rise_pd_s ##0 (!cmd.cs_n && !(cmd.ras_n && cmd.cas_n
    && cmd.we_n)) |-> ##[2:5] status.proto_error) else $error("bad exit not flagged");
  AST_INIT_WAIT: assert property ((state == st_wait_txpr && $past(state) != st_wait_txpr)
    |-> hi_cnt_r >= INIT_WAIT_CYC) else $error("init wait cut short");
  AST_ZQ_WAIT: assert property (($past(state) == st_zq_wait && state == st_idle)
    |-> zq_cnt_r >= TZQINIT_NCK - 1 && zq_cnt_r >= TDLLK_NCK - 1) else $error("zq wait short");
  AST_NOT_READY: assert property (state == st_zq_wait |-> !status.ready)
    else $error("ready during calibration");
endmodule // cke_power_props

bind cke_power_state cke_power_props #(
  .INIT_WAIT_CYC(INIT_WAIT_CYC), .TZQINIT_NCK(TZQINIT_NCK), .TDLLK_NCK(TDLLK_NCK)
) props_u (.clock(clock), .reset_n(reset_n), .mem_reset_n(mem_reset_n), .cke(cke), .odt(odt),
  .cmd(cmd), .a0(a0), .a8(a8), .odt_enable(odt_enable), .status(status), .state(state));

// ==== dv/cke_ctl_model.sv ====
// controller model driving reset, clock-enable, termination and command pins
// assumes the bench calls one task at a time; no write is ever issued
`timescale 1ns/1ps
module cke_ctl_model #(
  parameter int RST_HOLD = 2000,
  parameter int INIT_CYC = 20,
  parameter int TXPR_CYC = 8,
  parameter int MRD_CYC  = 4,
  parameter int ZQ_CYC   = 8
) (
  input  wire logic           clock,
  output logic                mem_reset_n,
  output logic                cke,
  output logic                odt,
  output cke_power_pkg::cmd_s cmd,
  output logic                a0,
  output logic                a8
);
  import cke_power_pkg::*;
  initial begin
    mem_reset_n = 1'b0;
    cke = 1'b0;
    odt = 1'b0;
    cmd = '1;
    a0 = 1'b0;
    a8 = 1'b0;
  end
  // deselected pins wander every cycle, so the device cannot lean on them
  task automatic tick(input logic k, input logic [3:0] c, input logic [3:0] b, input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      cke = k;
      cmd.cs_n = c[3];
      {cmd.ras_n, cmd.cas_n, cmd.we_n} = c[3] ? ~{cmd.ras_n, cmd.cas_n, cmd.we_n} : c[2:0];
      {cmd.a10, cmd.ba} = c[3] ? ~{cmd.a10, cmd.ba} : b;
      cmd.bank = cmd.ba;
    end
  endtask
  // termination request changes just after an edge, like every other pin
  task automatic drive_odt(input logic v);
    @(posedge clock);
    #1;
    odt = v;
  endtask
  task automatic init_seq();
    logic [2:0] mr [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
    mem_reset_n = 1'b0;
    cke = 1'b0;
    odt = 1'b0;
    repeat (RST_HOLD) @(posedge clock);
    #1;
    mem_reset_n = 1'b1;
    tick(1'b0, 4'h7, 4'h0, INIT_CYC + 8);
    tick(1'b1, 4'h7, 4'h0, TXPR_CYC + 8);
    foreach (mr[i]) begin
      a0 = 1'b0;
      a8 = (mr[i] == 3'h0);
      tick(1'b1, 4'h0, {1'b0, mr[i]}, 1);
      tick(1'b1, 4'h7, 4'h0, MRD_CYC + 3);
    end
    tick(1'b1, 4'h6, 4'h8, 1);
    tick(1'b1, 4'h7, 4'h0, ZQ_CYC + 8);
  endtask
endmodule // cke_ctl_model

// ==== dv/cke_power_state_bench.sv ====
// self-checking bench for the clock-enable power state block
// assumes the controller model drives every device pin except clock and reset_n, which the bench drives
`timescale 1ns/1ps
module cke_power_state_bench;
  import cke_power_pkg::*;
  logic    clock;
  logic    reset_n;
  logic    mem_reset_n;
  logic    cke;
  logic    odt;
  cmd_s    cmd;
  logic    a0;
  logic    a8;
  logic    odt_enable;
  status_s status;
  state_e  state;
  int      n_errors;
  int      checks_done;
  cke_power_state #(.INIT_WAIT_CYC(20), .TZQINIT_NCK(8), .TDLLK_NCK(8)) dut_u (
    .clock(clock), .reset_n(reset_n), .mem_reset_n(mem_reset_n), .cke(cke), .odt(odt),
    .cmd(cmd), .a0(a0), .a8(a8), .odt_enable(odt_enable), .status(status), .state(state));
  cke_ctl_model ctl_u (.clock(clock), .mem_reset_n(mem_reset_n), .cke(cke), .odt(odt),
    .cmd(cmd), .a0(a0), .a8(a8));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait; running out is a mismatch and ends the run
  task automatic wait_st(input state_e s, input int n);
    for (int i = 0; i < n && state !== s; i++) begin
      @(posedge clock);
      #2;
    end
    #2;
    chk(8'(state), 8'(s));
    if (state !== s) wrap_up();
  endtask
  task automatic t_init();
    fork
      ctl_u.init_seq();
      begin
        repeat (100) @(posedge clock);
        #2;
        chk(8'(status.odt_hiz), 8'h01);
        chk(8'(state), 8'(st_reset));
      end
    join
    wait_st(st_idle, 40);
    chk(8'(status.ready), 8'h01);
    chk(8'(status.odt_hiz), 8'h00);
    chk(8'(status.proto_error), 8'h00);
    chk(8'(status.all_idle), 8'h01);
    $display("test init done");
  endtask
  task automatic t_pd(input logic [3:0] exit_c);
    ctl_u.tick(1'b0, 4'hF, 4'h0, 6);
    wait_st(st_pd_pre, 4);
    chk(8'(status.power_down), 8'h01);
    ctl_u.tick(1'b1, exit_c, 4'h1, 1);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 6);
    if (exit_c != 4'h7) begin
      chk(8'(status.proto_error), 8'h01);
      chk(8'(state), 8'(st_pd_pre));
      ctl_u.tick(1'b0, 4'h7, 4'h0, 6);
      ctl_u.tick(1'b1, 4'h7, 4'h0, 6);
    end
    wait_st(st_idle, 12);
    $display("test power-down done");
  endtask
  task automatic t_pd_act();
    ctl_u.tick(1'b1, 4'h3, 4'h1, 1);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 4);
    chk(8'(status.all_idle), 8'h00);
    ctl_u.tick(1'b0, 4'h7, 4'h0, 6);
    wait_st(st_pd_act, 4);
    chk(8'(status.active_pd), 8'h01);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 6);
    ctl_u.tick(1'b1, 4'h2, 4'h8, 1);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 20);
    wait_st(st_idle, 20);
    $display("test active power-down done");
  endtask
  task automatic t_sr();
    ctl_u.drive_odt(1'b1);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 4);
    chk(8'(odt_enable), 8'h01);
    ctl_u.tick(1'b0, 4'h1, 4'h0, 1);
    ctl_u.tick(1'b0, 4'hF, 4'h0, 6);
    wait_st(st_self_ref, 4);
    chk(8'(status.self_refresh), 8'h01);
    chk(8'(odt_enable), 8'h00);
    ctl_u.tick(1'b1, 4'h7, 4'h0, 12);
    wait_st(st_idle, 20);
    ctl_u.drive_odt(1'b0);
    $display("test self refresh done");
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    n_errors = 0;
    checks_done = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    t_init();
    t_pd(4'h7);
    t_pd_act();
    t_sr();
    t_pd(4'h3);
    t_init();
    wrap_up();
  end
endmodule // cke_power_state_bench
